/* File: hw/seq_ctrl_pkg.sv */
// Constants and types for the pattern trigger sequencer control block.
// Assumes a single 40 MHz system clock and an APB register port.
package seq_ctrl_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int EXER_HALF_NS = 1000;
   localparam int EXER_CYC = (EXER_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int LOCK_VSYNCS = 2;
   localparam int DW = 16;
   localparam int EV_W = 6;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_INT_ST = 8'h08;
   localparam logic [7:0] A_INT_MASK = 8'h0C;
   localparam logic [7:0] A_TOUT0 = 8'h10;
   localparam logic [7:0] A_TOUT1 = 8'h14;
   localparam logic [7:0] A_TIN0 = 8'h18;
   localparam logic [7:0] A_TIN1 = 8'h1C;
   localparam logic [7:0] A_ILL_DLY = 8'h20;
   localparam logic [7:0] A_POL = 8'h24;
   localparam logic [7:0] A_MIN_PW = 8'h28;
   localparam logic [7:0] A_ILL_UNIT = 8'h2C;
   localparam logic [7:0] A_RANGE = 8'h30;
   localparam logic [7:0] A_TIMEOUT = 8'h34;
   localparam logic [7:0] A_BATCH = 8'h38;
   localparam int C_VIDEO = 0;
   localparam int C_EXER = 1;
   localparam int C_MOD = 2;
   localparam int C_RANGE = 3;
   localparam int S_LOCKED = 0;
   localparam int S_LOST = 1;
   localparam int S_BUSY = 2;
   localparam int EV_STEP = 0;
   localparam int EV_LOST = 1;
   localparam int EV_LOCK = 2;
   localparam int EV_TIN0 = 3;
   localparam int EV_TIN1 = 4;
   localparam int EV_BDONE = 5;
   localparam int P_TOUT = 0;
   localparam int P_TIN = 2;
   localparam int P_ILL = 4;
   localparam int B_RUN = 8;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [15:0] MIN_PW_RST = 16'h0004;
   localparam logic [15:0] UNIT_RST = 16'h0002;
   typedef struct packed {
      logic [7:0] end_block;
      logic [7:0] start_block;
   } block_range_type;
   typedef struct packed {
      logic       last;
      logic [7:0] addr;
      logic [31:0] data;
   } batch_entry_type;
   localparam int BATCH_DEPTH = 4;
   localparam batch_entry_type BATCH_ROM [BATCH_DEPTH] = '{
      '{1'b0, A_POL, 32'h0000_0000},
      '{1'b1, A_MIN_PW, 32'h0000_0008},
      '{1'b0, A_ILL_DLY, 32'h0000_0010},
      '{1'b1, A_CTRL, 32'h0000_0001}};
endpackage

/* File: hw/seq_ctrl.sv */
// Pattern trigger sequencer control: video lock, trigger and illumination
// delays, modulation, block range, mirror exercise and stored batches.
// Assumes vsync and trigger pins are asynchronous; pattern and plane strobes
// come from the sequencer on clk.
`timescale 1ns/1ps
module delay_fire #(parameter int W = 16) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         start,
   input  wire logic [W-1:0] delay,
   output logic              fire
);
   import seq_ctrl_pkg::*;
   typedef enum logic {D_IDLE = 1'b0, D_COUNT = 1'b1} dstate_type;
   dstate_type     state, next_state;
   logic [W-1:0]   cnt, next_cnt;
   logic           next_fire;
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_fire = 1'b0;
      case (state)
         D_IDLE: begin
            if (start) begin
               next_state = D_COUNT;
               next_cnt = '0;
            end
         end
         D_COUNT: begin
            next_cnt = cnt + 1'b1;
            if (cnt == delay) begin
               next_fire = 1'b1;
               next_state = D_IDLE;
            end
            // A fresh start drops a fire still owed to the old pattern
            if (start) begin
               next_cnt = '0;
               next_state = D_COUNT;
               next_fire = 1'b0;
            end
         end
         default: next_state = D_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= D_IDLE;
         cnt <= '0;
         fire <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         fire <= next_fire;
      end
   end
   AST_DELAY_EXACT: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(fire) |-> $past(state) == D_COUNT && $past(cnt) == $past(delay))
      else $error("delay fired at wrong count");
endmodule

module seq_ctrl #(
   parameter int          NBLK            = 16,
   parameter logic [31:0] TIMEOUT_DEFAULT = 32'h0020_0000,
   parameter logic [1:0]  DEFAULT_BATCH   = 2'h0,
   parameter logic        DEFAULT_EN      = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              vsync_pin,
   input  wire logic [1:0]        trig_in_pin,
   input  wire logic              pattern_start,
   input  wire logic              plane_start,
   input  wire logic [2:0]        plane_weight,
   output logic                   pattern_step,
   output logic                   solid_curtain,
   output logic [1:0]             trig_in_event,
   output logic [1:0]             trig_out_pin,
   output logic [2:0]             illumination_enable,
   output logic [NBLK-1:0]        block_enable,
   output logic                   exercise_phase,
   output logic                   irq
);
   import seq_ctrl_pkg::*;
   logic [31:0] ctrl, timeout;
   logic [EV_W-1:0] int_st, int_mask, ev;
   logic [DW-1:0] tout_dly [2];
   logic [DW-1:0] tin_dly [2];
   logic [DW-1:0] ill_dly, min_pw, unit;
   logic [7:0] pol;
   block_range_type active_block_range;
   // Register writes come from APB or the batch engine, never both
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic        apb_wr, apb_acc;
   logic [1:0]  bidx, next_bidx;
   logic        busy, next_busy, bdone, next_bdone, boot, next_boot;
   assign apb_acc = psel && penable && !busy;
   assign apb_wr = apb_acc && pwrite;
   assign pready = !busy;
   assign pslverr = 1'b0;
   always_comb begin
      wr_en = apb_wr;
      wr_addr = paddr;
      wr_data = pwdata;
      if (busy) begin
         wr_en = 1'b1;
         wr_addr = BATCH_ROM[bidx].addr;
         wr_data = BATCH_ROM[bidx].data;
      end
   end
   // Batch engine: replays stored writes in order, stalling APB
   always_comb begin
      next_bidx = bidx;
      next_busy = busy;
      next_bdone = 1'b0;
      next_boot = 1'b0;
      if (boot && DEFAULT_EN) begin
         next_busy = 1'b1;
         next_bidx = DEFAULT_BATCH;
      end else if (busy) begin
         next_bidx = bidx + 1'b1;
         if (BATCH_ROM[bidx].last) begin
            next_busy = 1'b0;
            next_bdone = 1'b1;
         end
      end else if (apb_wr && paddr == A_BATCH && pwdata[B_RUN]) begin
         next_busy = 1'b1;
         next_bidx = pwdata[1:0];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bidx <= 2'h0;
         busy <= 1'b0;
         bdone <= 1'b0;
         boot <= 1'b1;
      end else begin
         bidx <= next_bidx;
         busy <= next_busy;
         bdone <= next_bdone;
         boot <= next_boot;
      end
   end
   // Pin synchronisers
   logic [2:0] pin_s1, pin_s2, pin_d;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         pin_d <= 3'h0;
      end else begin
         pin_s1 <= {trig_in_pin, vsync_pin};
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end
   logic vs_edge;
   logic [1:0] tin_lvl, tin_prev, tin_edge;
   assign vs_edge = pin_s2[0] && !pin_d[0];
   assign tin_lvl = pin_s2[2:1] ^ pol[P_TIN+:2];
   assign tin_prev = pin_d[2:1] ^ pol[P_TIN+:2];
   assign tin_edge = tin_lvl & ~tin_prev;
   // Source lock tracking
   logic [31:0] vs_timer, next_vs_timer;
   logic [1:0]  vs_cnt, next_vs_cnt;
   logic        locked, next_locked, lost_ev, lock_ev;
   always_comb begin
      next_vs_timer = vs_timer + 1'b1;
      next_vs_cnt = vs_cnt;
      next_locked = locked;
      if (vs_edge) begin
         next_vs_timer = '0;
         if (vs_cnt != 2'(LOCK_VSYNCS))
            next_vs_cnt = vs_cnt + 1'b1;
         else
            next_locked = 1'b1;
      end else if (vs_timer >= timeout) begin
         next_vs_timer = vs_timer;
         next_vs_cnt = '0;
         next_locked = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vs_timer <= '0;
         vs_cnt <= '0;
         locked <= 1'b0;
      end else begin
         vs_timer <= next_vs_timer;
         vs_cnt <= next_vs_cnt;
         locked <= next_locked;
      end
   end
   assign lost_ev = locked && !next_locked;
   assign lock_ev = !locked && next_locked;
   assign solid_curtain = ctrl[C_VIDEO] && !locked;
   assign pattern_step = ctrl[C_VIDEO] && locked && vs_edge;
   // Trigger and illumination delays
   logic [1:0] tout_fire;
   logic       ill_fire;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_trig
         delay_fire #(.W(DW)) u_tout (.clk(clk), .sys_rst(sys_rst),
            .start(pattern_start), .delay(tout_dly[g]), .fire(tout_fire[g]));
         delay_fire #(.W(DW)) u_tin (.clk(clk), .sys_rst(sys_rst),
            .start(tin_edge[g]), .delay(tin_dly[g]), .fire(trig_in_event[g]));
      end
   endgenerate
   delay_fire #(.W(DW)) u_ill (.clk(clk), .sys_rst(sys_rst),
      .start(pattern_start), .delay(ill_dly), .fire(ill_fire));
   // Modulated window: unit scaled by plane weight, floored at min_pw
   logic [1:0]    tout_raw, next_tout_raw;
   logic          ill_on, next_ill_on, ill_armed, next_ill_armed;
   logic [DW-1:0] ill_cnt, next_ill_cnt, plane_len;
   assign plane_len = (DW'(unit << plane_weight) < min_pw) ? min_pw
                    : DW'(unit << plane_weight);
   always_comb begin
      next_tout_raw = tout_raw | tout_fire;
      next_ill_on = ill_on;
      next_ill_armed = ill_armed | ill_fire;
      next_ill_cnt = ill_cnt;
      if (pattern_start) begin
         next_tout_raw = 2'b00;
         next_ill_on = 1'b0;
         next_ill_armed = 1'b0;
      end else if (!ctrl[C_MOD]) begin
         next_ill_on = ill_on | ill_fire;
         // Preload so a switch into modulation cannot cut a lit pulse short
         if (!ill_on)
            next_ill_cnt = min_pw - 1'b1;
      end else begin
         if (ill_on && ill_cnt != '0)
            next_ill_cnt = ill_cnt - 1'b1;
         else if (ill_on)
            next_ill_on = 1'b0;
         if ((ill_armed || ill_fire) && plane_start) begin
            next_ill_on = 1'b1;
            next_ill_cnt = plane_len - 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tout_raw <= 2'b00;
         ill_on <= 1'b0;
         ill_armed <= 1'b0;
         ill_cnt <= '0;
      end else begin
         tout_raw <= next_tout_raw;
         ill_on <= next_ill_on;
         ill_armed <= next_ill_armed;
         ill_cnt <= next_ill_cnt;
      end
   end
   assign trig_out_pin = tout_raw ^ pol[P_TOUT+:2];
   assign illumination_enable = {3{ill_on}} ^ pol[P_ILL+:3];
   // Block range and mirror exercise; host keeps sequence stopped here
   localparam int EXW = $clog2(EXER_CYC + 1);
   logic [EXW-1:0] ex_div, next_ex_div;
   logic           next_phase;
   always_comb begin
      next_ex_div = ex_div + 1'b1;
      next_phase = exercise_phase;
      if (!ctrl[C_EXER]) begin
         next_ex_div = '0;
         next_phase = 1'b0;
      end else if (ex_div == EXW'(EXER_CYC - 1)) begin
         next_ex_div = '0;
         next_phase = !exercise_phase;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ex_div <= '0;
         exercise_phase <= 1'b0;
      end else begin
         ex_div <= next_ex_div;
         exercise_phase <= next_phase;
      end
   end
   always_comb begin
      for (int i = 0; i < NBLK; i++) begin
         block_enable[i] = ctrl[C_EXER] || !ctrl[C_RANGE] ||
            (8'(i) >= active_block_range.start_block &&
             8'(i) <= active_block_range.end_block);
      end
   end
   // Register file; set beats write-one-to-clear
   assign ev = {bdone, |trig_in_event[1], trig_in_event[0], lock_ev, lost_ev,
                pattern_step};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= '0;
         int_st <= '0;
         int_mask <= '0;
         tout_dly <= '{default: '0};
         tin_dly <= '{default: '0};
         ill_dly <= '0;
         pol <= POL_RST;
         min_pw <= MIN_PW_RST;
         unit <= UNIT_RST;
         active_block_range <= '0;
         timeout <= TIMEOUT_DEFAULT;
      end else begin
         int_st <= (int_st & ~((wr_en && wr_addr == A_INT_ST) ?
                   wr_data[EV_W-1:0] : '0)) | ev;
         if (wr_en) begin
            case (wr_addr)
               A_CTRL: ctrl <= wr_data;
               A_INT_MASK: int_mask <= wr_data[EV_W-1:0];
               A_TOUT0: tout_dly[0] <= wr_data[DW-1:0];
               A_TOUT1: tout_dly[1] <= wr_data[DW-1:0];
               A_TIN0: tin_dly[0] <= wr_data[DW-1:0];
               A_TIN1: tin_dly[1] <= wr_data[DW-1:0];
               A_ILL_DLY: ill_dly <= wr_data[DW-1:0];
               A_POL: pol <= wr_data[7:0];
               A_MIN_PW: min_pw <= wr_data[DW-1:0];
               A_ILL_UNIT: unit <= wr_data[DW-1:0];
               A_RANGE: active_block_range <= wr_data[15:0];
               A_TIMEOUT: timeout <= wr_data;
               default: ;
            endcase
         end
      end
   end
   always_comb begin
      prdata = '0;
      if (apb_acc && !pwrite) begin
         case (paddr)
            A_CTRL: prdata = ctrl;
            A_STATUS: prdata = 32'({busy, solid_curtain, locked});
            A_INT_ST: prdata = 32'(int_st);
            A_INT_MASK: prdata = 32'(int_mask);
            A_TOUT0: prdata = 32'(tout_dly[0]);
            A_TOUT1: prdata = 32'(tout_dly[1]);
            A_TIN0: prdata = 32'(tin_dly[0]);
            A_TIN1: prdata = 32'(tin_dly[1]);
            A_ILL_DLY: prdata = 32'(ill_dly);
            A_POL: prdata = 32'(pol);
            A_MIN_PW: prdata = 32'(min_pw);
            A_ILL_UNIT: prdata = 32'(unit);
            A_RANGE: prdata = 32'(active_block_range);
            A_TIMEOUT: prdata = timeout;
            A_BATCH: prdata = 32'(bidx);
            default: prdata = '0;
         endcase
      end
   end
   assign irq = |(int_st & int_mask);
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [DW-1:0] hi_cnt;
   always_ff @(posedge clk) begin
      if (sys_rst || !ill_on)
         hi_cnt <= '0;
      else
         hi_cnt <= hi_cnt + 1'b1;
   end
   sequence s_stable_mod;
      ctrl[C_MOD] && !$past(pattern_start);
   endsequence
   AST_STEP_ON_VSYNC: assert property (ctrl[C_VIDEO] && locked && vs_edge
      |-> pattern_step) else $error("vsync did not step pattern");
   AST_CURTAIN: assert property (ctrl[C_VIDEO] && !locked |-> solid_curtain)
      else $error("no curtain while source lost");
   AST_LOCK_TIMEOUT: assert property (!vs_edge && vs_timer >= timeout
      |=> !locked) else $error("lock kept after timeout");
   AST_LOCK_STATUS: assert property (apb_acc && !pwrite && paddr == A_STATUS
      |-> prdata[S_LOCKED] == locked) else $error("status lock bit wrong");
   AST_TOUT_POL: assert property ($rose(tout_fire[0]) && !pattern_start
      |=> trig_out_pin[0] != pol[P_TOUT]) else $error("trigger out polarity");
   AST_MIN_WIDTH: assert property (s_stable_mod ##0 $fell(ill_on)
      |-> $past(hi_cnt) + 1'b1 >= min_pw) else $error("illumination too short");
   AST_BLOCK_OFF: assert property (ctrl[C_RANGE] && !ctrl[C_EXER] &&
      active_block_range.start_block > 8'h00 |-> !block_enable[0])
      else $error("unselected block enabled");
   AST_EXER_TOGGLE: assert property (ctrl[C_EXER] && ex_div == EXW'(EXER_CYC - 1)
      |=> exercise_phase != $past(exercise_phase)) else $error("exercise stalled");
   AST_BATCH_STALL: assert property (busy |-> !pready ##0 wr_en)
      else $error("batch write not applied");
endmodule

/* File: tb/far_side_model.sv */
// Far-side model: video source vsync and an external trigger device.
// Assumes the bench clock; pins change just after rising edges only.
`timescale 1ns/1ps
module far_side_model #(
   parameter int PERIOD = 60
) (
   input  wire logic       clk,
   input  wire logic       vs_run,
   input  wire logic [1:0] trig_req,
   output logic            vsync_pin,
   output logic [1:0]      trig_in_pin
);
   int vs_cnt;
   int tr_cnt [2];

   // A stopped source gives no sync edges at all, so loss is real
   always @(posedge clk) begin
      vs_cnt    <= vs_run ? (vs_cnt + 1) % PERIOD : 0;
      vsync_pin <= vs_run && (vs_cnt < 4);
      for (int i = 0; i < 2; i++) begin
         tr_cnt[i]      <= trig_req[i] ? 3 : (tr_cnt[i] > 0 ? tr_cnt[i] - 1 : 0);
         trig_in_pin[i] <= trig_req[i] || (tr_cnt[i] > 1);
      end
   end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the sequencer control block.
// Assumes seq_ctrl_pkg and the far-side model; APB master here.
`timescale 1ns/1ps
module tb;
   import seq_ctrl_pkg::*;
   logic              clk;
   logic              sys_rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              pattern_start;
   logic              plane_start;
   logic [2:0]        plane_weight;
   logic              vs_run;
   logic [1:0]        trig_req;
   logic              vsync_pin;
   logic [1:0]        trig_in_pin;
   logic              pattern_step;
   logic              solid_curtain;
   logic [1:0]        trig_in_event;
   logic [1:0]        trig_out_pin;
   logic [2:0]        illumination_enable;
   logic [15:0]       block_enable;
   logic              exercise_phase;
   logic              irq;
   logic [31:0]       exp_q [$];
   logic [15:0]       m;
   int                n_fail;
   int                cmp_count;
   int                seed;
   int                n;
   int                s;
   int                e;
   int                w;
   int                dly [3];

   seq_ctrl #(.NBLK(16), .TIMEOUT_DEFAULT(32'h0000_0100), .DEFAULT_BATCH(2'h0),
      .DEFAULT_EN(1'b1)) u_seq_ctrl (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .vsync_pin(vsync_pin),
      .trig_in_pin(trig_in_pin), .pattern_start(pattern_start),
      .plane_start(plane_start), .plane_weight(plane_weight),
      .pattern_step(pattern_step), .solid_curtain(solid_curtain),
      .trig_in_event(trig_in_event), .trig_out_pin(trig_out_pin),
      .illumination_enable(illumination_enable), .block_enable(block_enable),
      .exercise_phase(exercise_phase), .irq(irq));

   far_side_model #(.PERIOD(60)) u_far_side_model (.clk(clk), .vs_run(vs_run),
      .trig_req(trig_req), .vsync_pin(vsync_pin), .trig_in_pin(trig_in_pin));

   always #12.5 clk = ~clk;

   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read data is noted here and compared by the monitor below
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      if (!wr)
         exp_q.push_back(d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 200);
      if (k >= 200) begin
         n_fail++;
         final_report();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1)
         chk(32'(pslverr), 32'h0);
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
         chk(prdata, exp_q.pop_front());
   end

   function automatic logic probe(input int k);
      case (k)
         0, 1: return trig_out_pin[k] === 1'b1;
         2: return illumination_enable[0] === 1'b1;
         3, 4: return trig_in_event[k-3] === 1'b1;
         5: return pattern_step === 1'b1;
         6: return vsync_pin === 1'b1;
         7: return exercise_phase === 1'b1;
         9: return vsync_pin === 1'b0;
         default: return exercise_phase === 1'b0;
      endcase
   endfunction

   task automatic count_to(input int k, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (!probe(k) && c < 400);
      if (c >= 400) begin
         n_fail++;
         final_report();
      end
   endtask

   task automatic pulse_pat();
      @(posedge clk);
      pattern_start <= 1'b1;
      @(posedge clk);
      pattern_start <= 1'b0;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      final_report();
   end

   initial begin
      clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; pattern_start = 1'b0; plane_start = 1'b0;
      plane_weight = 3'h0; vs_run = 1'b0; trig_req = 2'b00;
      n_fail = 0; cmp_count = 0; seed = 32'h562427ea;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, A_MIN_PW, 32'h0000_0008);
      apb(1'b0, A_POL, 32'h0000_0000);
      apb(1'b0, A_ILL_UNIT, 32'h0000_0002);
      apb(1'b0, A_TIMEOUT, 32'h0000_0100);
      apb(1'b0, A_STATUS, 32'h0000_0000);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      apb(1'b1, A_POL, 32'h0000_0073);
      repeat (2) @(posedge clk);
      #1 chk(32'(trig_out_pin), 32'h3);
      chk(32'(illumination_enable), 32'h7);
      apb(1'b1, A_POL, 32'h0000_0000);
      apb(1'b1, A_INT_MASK, 32'h0000_0020);
      #1 chk(32'(irq), 32'h1);
      apb(1'b1, A_INT_ST, 32'h0000_0020);
      #1 chk(32'(irq), 32'h0);
      apb(1'b1, A_ILL_DLY, 32'h0000_0033);
      apb(1'b1, A_BATCH, 32'h0000_0102);
      apb(1'b0, A_ILL_DLY, 32'h0000_0010);
      apb(1'b0, A_CTRL, 32'h0000_0001);
      #1 chk(32'(irq), 32'h1);
      @(posedge clk);
      vs_run <= 1'b1;
      repeat (250) @(posedge clk);
      apb(1'b0, A_STATUS, 32'h0000_0001);
      // Start from a low pin so the step is timed from a fresh rising edge
      count_to(9, n);
      count_to(6, n);
      count_to(5, n);
      chk(32'(n >= 2 && n <= 4), 32'h1);
      chk(32'(solid_curtain), 32'h0);
      @(posedge clk);
      vs_run <= 1'b0;
      repeat (400) @(posedge clk);
      apb(1'b0, A_STATUS, 32'h0000_0002);
      #1 chk(32'(solid_curtain), 32'h1);
      apb(1'b1, A_INT_MASK, 32'h0000_0002);
      #1 chk(32'(irq), 32'h1);
      @(posedge clk);
      vs_run <= 1'b1;
      repeat (250) @(posedge clk);
      apb(1'b0, A_STATUS, 32'h0000_0001);
      apb(1'b1, A_INT_MASK, 32'h0000_0000);
      apb(1'b1, A_CTRL, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         dly[i] = 3 + ($random(seed) & 31);
         apb(1'b1, (i == 2) ? A_ILL_DLY : A_TOUT0 + 8'(4 * i), 32'(dly[i]));
      end
      for (int i = 0; i < 3; i++) begin
         pulse_pat();
         count_to(i, n);
         chk(32'(n), 32'(dly[i] + 2));
      end
      apb(1'b1, A_CTRL, 32'h0000_0004);
      for (int i = 0; i < 3; i++) begin
         w = (i == 0) ? 0 : ($random(seed) & 7);
         pulse_pat();
         repeat (dly[2] + 4) @(posedge clk);
         plane_start  <= 1'b1;
         plane_weight <= 3'(w);
         @(posedge clk);
         plane_start <= 1'b0;
         n = 0;
         repeat (300) begin
            #1 n += int'(illumination_enable[0] === 1'b1);
            @(posedge clk);
         end
         chk(32'(n), 32'((2 << w) > 8 ? (2 << w) : 8));
      end
      for (int i = 0; i < 2; i++) begin
         dly[i] = 4 + ($random(seed) & 15);
         apb(1'b1, A_TIN0 + 8'(4 * i), 32'(dly[i]));
         @(posedge clk);
         trig_req[i] <= 1'b1;
         @(posedge clk);
         trig_req[i] <= 1'b0;
         count_to(3 + i, n);
         chk(32'(n >= dly[i] + 2 && n <= dly[i] + 7), 32'h1);
      end
      for (int i = 0; i < 3; i++) begin
         s = (i == 0) ? 6 : ($random(seed) & 15);
         e = (i == 0) ? 8 : s + ($unsigned($random(seed)) % (16 - s));
         for (int b = 0; b < 16; b++)
            m[b] = (b >= s) && (b <= e);
         apb(1'b1, A_RANGE, {16'h0000, 8'(e), 8'(s)});
         apb(1'b1, A_CTRL, 32'h0000_0008);
         #1 chk(32'(block_enable), 32'(m));
      end
      apb(1'b1, A_CTRL, 32'h0000_0000);
      apb(1'b1, A_CTRL, 32'h0000_0002);
      #1 chk(32'(block_enable), 32'h0000_ffff);
      count_to(7, n);
      count_to(8, n);
      chk(32'(n), 32'(EXER_CYC));
      apb(1'b1, A_CTRL, 32'h0000_0000);
      final_report();
   end
endmodule
